// ### include/vrt_pkg.sv
// Shared constants, register map and carrier types of the velocity ramp block
package vrt_pkg;
   // Clock and control cycle timing
   localparam int CLK_PERIOD_NS = 100; // 10 MHz reference clock
   localparam int CTRL_CYCLE_NS = 1000000; // 1 ms control cycle
   localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
   // Register byte offsets
   localparam logic [7:0] REG_GEN_CTRL = 8'h00;
   localparam logic [7:0] REG_GEN_TARGET = 8'h04;
   localparam logic [7:0] REG_GEN_OFFSET = 8'h08;
   localparam logic [7:0] REG_GEN_AMPL = 8'h0C;
   localparam logic [7:0] REG_GEN_DUR1 = 8'h10;
   localparam logic [7:0] REG_GEN_DUR2 = 8'h14;
   localparam logic [7:0] REG_GEN_PERIOD = 8'h18;
   localparam logic [7:0] REG_GEN_OUT = 8'h1C;
   localparam logic [7:0] REG_VEL_CTRL = 8'h20;
   localparam logic [7:0] REG_ACC1 = 8'h24;
   localparam logic [7:0] REG_FINAL_SPEED = 8'h28;
   localparam logic [7:0] REG_ACC2 = 8'h2C;
   localparam logic [7:0] REG_DEC1 = 8'h30;
   localparam logic [7:0] REG_DEC2 = 8'h34;
   localparam logic [7:0] REG_ACC_FACTOR = 8'h38;
   localparam logic [7:0] REG_EXT_CMD = 8'h3C;
   localparam logic [7:0] REG_RAMP_OUT = 8'h40;
   localparam logic [7:0] REG_STATUS = 8'h44;
   localparam logic [7:0] REG_TABLE_BASE = 8'h80; // 16 words up to 0xBC
   // Reset values and limits
   localparam logic [31:0] GEN_AMPL_RST = 32'h000186A0; // 10,0000 in 1e-4 units
   localparam logic [31:0] GEN_AMPL_MIN = 32'h00000001; // 0,0001
   localparam logic [9:0] VEL_CTRL_RST = 10'h000;
   localparam logic [9:0] VEL_CTRL_MAX = 10'h3FF;
   localparam logic [15:0] ACC_FACTOR_RST = 16'h0064; // 1,00
   localparam logic [15:0] ACC_FACTOR_MIN = 16'h0064; // 1,00
   localparam logic [15:0] ACC_FACTOR_MAX = 16'h2710; // 100,00
   localparam logic [15:0] ACC_FACTOR_ONE = 16'h0064;
   // Velocity control word field positions
   localparam int VC_IDX_LSB = 0; // Fixed value index, 4 bits
   localparam int VC_IDX_W = 4;
   localparam int VC_SRC_TABLE = 4; // 1 = fixed value table
   localparam int VC_RUNUP_STOP = 5; // Freeze ramp output
   localparam int VC_MASK_EN = 6; // Speed masking active
   localparam int VC_MPOT_EN = 7; // Motor potentiometer source
   localparam int VC_MPOT_UP = 8;
   localparam int VC_MPOT_DN = 9;
   // Saturation limits of 32-bit signed values
   localparam logic signed [32:0] SAT_MAX = 33'sh7FFFFFFF;
   localparam logic signed [32:0] SAT_MIN = -33'sh7FFFFFFF;
   // Generator phases
   typedef enum logic [1:0] {G_IDLE, G_HIGH, G_LOW, G_REST} vrt_gen_st_t;
   // Avalon request carrier
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } vrt_avl_req_t;
   // Generator result carrier
   typedef struct packed {
      logic write;
      logic [15:0] target;
      logic [31:0] value;
   } vrt_gen_out_t;
endpackage

// ### rtl/vrt_table.sv
// Fixed velocity command value memory with registered read data
`timescale 1ns/1ps
module vrt_table import vrt_pkg::*; #(
   parameter int DEPTH = 16,
   parameter int AW = 4,
   parameter int DW = 32
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   // Whole memory state
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } vrt_tab_st_t;
   vrt_tab_st_t s_q, s_d;

   // Write port and registered read port
   always_comb begin
      s_d = s_q;
      if (wr_en) begin
         s_d.mem[wr_addr] = wr_data;
      end
      s_d.rd = s_q.mem[rd_addr];
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd;
endmodule

// ### rtl/vrt_core.sv
// Velocity ramp generator and square-wave test signal generator
`timescale 1ns/1ps
module vrt_core import vrt_pkg::*; #(
   parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS,
   parameter int TAB_DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire vrt_avl_req_t avs_req,
   output logic avs_waitrequest,
   output logic [31:0] avs_readdata,
   input wire logic [9:0] vel_ctrl_in,
   input wire logic vel_ctrl_in_wr,
   output vrt_gen_out_t gen_out,
   output logic [31:0] ramp_out,
   output logic ctrl_tick
);
   // All state of the core
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic gen_en;
      logic [15:0] target;
      logic [31:0] offset;
      logic [31:0] ampl;
      logic [31:0] dur1;
      logic [31:0] dur2;
      logic [31:0] period;
      logic [9:0] vctrl;
      logic [31:0] acc1;
      logic [31:0] final_spd;
      logic [31:0] acc2;
      logic [31:0] dec1;
      logic [31:0] dec2;
      logic [15:0] factor;
      logic [31:0] ext_cmd;
      logic [31:0] mpot;
      vrt_gen_st_t gst;
      logic [31:0] pcnt;
      logic [31:0] cnt;
      vrt_gen_out_t gout;
      logic [31:0] rout;
      logic [31:0] div;
      logic tick;
      logic stage2;
   } vrt_st_t;
   vrt_st_t s_q, s_d;

   // Table interface
   logic tab_wr; // Bus write into the table
   logic [31:0] tab_rd; // Selected fixed value
   logic [3:0] tab_idx; // Binary coded index

   // Saturate a 33-bit signed value into 32 bits
   function automatic logic [31:0] sat32(input logic signed [32:0] v);
      logic [31:0] r;
      r = v[31:0];
      if (v > SAT_MAX) begin
         r = SAT_MAX[31:0];
      end else if (v < SAT_MIN) begin
         r = SAT_MIN[31:0];
      end
      return r;
   endfunction

   // Magnitude of a signed 32-bit value
   function automatic logic [32:0] mag(input logic [31:0] v);
      logic signed [32:0] w;
      w = {v[31], v};
      return (w < 0) ? 33'(-w) : 33'(w);
   endfunction

   // Register write decode
   logic wr_go; // Write takes effect this edge
   // Read data latched in the wait cycle, so it stands when waitrequest drops
   logic rd_go; // Read data prepared this edge
   assign wr_go = avs_req.write & s_q.ack;
   assign rd_go = avs_req.read & ~s_q.ack;
   assign tab_wr = wr_go && (avs_req.address[7:6] == REG_TABLE_BASE[7:6]);
   // Table read lags the index by a clock, settled long before a tick
   assign tab_idx = s_q.vctrl[VC_IDX_LSB +: VC_IDX_W];

   // Fixed command value memory
   vrt_table #(
      .DEPTH(TAB_DEPTH),
      .AW(4),
      .DW(32)
   ) u_table (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .wr_en(tab_wr),
      .wr_addr(avs_req.address[5:2]),
      .wr_data(avs_req.writedata),
      .rd_addr(tab_idx),
      .rd_data(tab_rd)
   );

   // Ramp working values
   logic [31:0] cmd; // Selected velocity command
   logic [32:0] out_mag; // Ramp output magnitude
   logic [32:0] cmd_mag; // Command magnitude
   logic [47:0] acc_prod; // Slope times factor
   logic [31:0] acc_eff; // Effective slope one
   logic [31:0] slope; // Active slope
   logic signed [32:0] diff; // Command minus output
   logic decel; // Moving toward zero
   logic use_acc2; // Second acceleration stage selected
   logic signed [32:0] half; // Half amplitude

   // Command source, slope selection
   always_comb begin
      // Source priority: potentiometer, table, external
      if (s_q.vctrl[VC_MPOT_EN]) begin
         cmd = s_q.mpot;
      end else if (s_q.vctrl[VC_SRC_TABLE]) begin
         cmd = tab_rd;
      end else begin
         cmd = s_q.ext_cmd;
      end
      out_mag = mag(s_q.rout);
      cmd_mag = mag(cmd);
      diff = $signed({cmd[31], cmd}) - $signed({s_q.rout[31], s_q.rout});
      // Moving toward zero or across it counts as deceleration
      decel = (cmd_mag < out_mag) || (cmd[31] != s_q.rout[31] && out_mag != '0);
      // Factor is held times 100, so divide back after the product
      acc_prod = s_q.acc1 * s_q.factor;
      if (s_q.vctrl[VC_MASK_EN]) begin
         acc_eff = 32'(acc_prod / 48'(ACC_FACTOR_ONE));
      end else begin
         acc_eff = s_q.acc1;
      end
      // Stage two only above threshold and with a non-zero slope
      use_acc2 = !decel && (out_mag > {1'b0, s_q.final_spd}) && (s_q.acc2 != '0);
      if (decel) begin
         // Below threshold use second deceleration slope
         if (out_mag < {1'b0, s_q.final_spd}) begin
            slope = s_q.dec2;
         end else begin
            slope = s_q.dec1;
         end
      end else if (use_acc2) begin
         slope = s_q.acc2;
      end else begin
         slope = acc_eff;
      end
      // Half amplitude either side of the offset
      half = $signed({2'b00, s_q.ampl[31:1]});
   end

   // Main next-state process
   always_comb begin
      s_d = s_q;
      s_d.ack = (avs_req.read | avs_req.write) & ~s_q.ack;
      s_d.gout.write = 1'b0;
      // Read mux prepared one cycle before the answer
      if (rd_go) begin
         case (avs_req.address)
            REG_GEN_CTRL: s_d.rdata = {31'h0, s_q.gen_en};
            REG_GEN_TARGET: s_d.rdata = {16'h0, s_q.target};
            REG_GEN_OFFSET: s_d.rdata = s_q.offset;
            REG_GEN_AMPL: s_d.rdata = s_q.ampl;
            REG_GEN_DUR1: s_d.rdata = s_q.dur1;
            REG_GEN_DUR2: s_d.rdata = s_q.dur2;
            REG_GEN_PERIOD: s_d.rdata = s_q.period;
            REG_GEN_OUT: s_d.rdata = s_q.gout.value;
            REG_VEL_CTRL: s_d.rdata = {22'h0, s_q.vctrl};
            REG_ACC1: s_d.rdata = s_q.acc1;
            REG_FINAL_SPEED: s_d.rdata = s_q.final_spd;
            REG_ACC2: s_d.rdata = s_q.acc2;
            REG_DEC1: s_d.rdata = s_q.dec1;
            REG_DEC2: s_d.rdata = s_q.dec2;
            REG_ACC_FACTOR: s_d.rdata = {16'h0, s_q.factor};
            REG_EXT_CMD: s_d.rdata = s_q.ext_cmd;
            REG_RAMP_OUT: s_d.rdata = s_q.rout;
            REG_STATUS: s_d.rdata = {28'h0, s_q.stage2, s_q.gst == G_IDLE, s_q.gst};
            default: s_d.rdata = 32'h0; // Unmapped and table read as zero
         endcase
      end
      // Register writes at the acknowledging edge
      if (wr_go) begin
         case (avs_req.address)
            REG_GEN_CTRL: s_d.gen_en = avs_req.writedata[0];
            REG_GEN_TARGET: s_d.target = avs_req.writedata[15:0];
            REG_GEN_OFFSET: s_d.offset = avs_req.writedata;
            REG_GEN_AMPL: begin
               // Amplitude never below its minimum
               if (avs_req.writedata < GEN_AMPL_MIN || avs_req.writedata[31]) begin
                  s_d.ampl = GEN_AMPL_MIN;
               end else begin
                  s_d.ampl = avs_req.writedata;
               end
            end
            REG_GEN_DUR1: s_d.dur1 = avs_req.writedata;
            REG_GEN_DUR2: s_d.dur2 = avs_req.writedata;
            REG_GEN_PERIOD: s_d.period = avs_req.writedata;
            REG_VEL_CTRL: s_d.vctrl = avs_req.writedata[9:0] & VEL_CTRL_MAX;
            REG_ACC1: s_d.acc1 = avs_req.writedata;
            REG_FINAL_SPEED: s_d.final_spd = avs_req.writedata;
            REG_ACC2: s_d.acc2 = avs_req.writedata;
            REG_DEC1: s_d.dec1 = avs_req.writedata;
            REG_DEC2: s_d.dec2 = avs_req.writedata;
            REG_ACC_FACTOR: begin
               // Factor kept within 1,00 .. 100,00
               if (avs_req.writedata[15:0] < ACC_FACTOR_MIN || avs_req.writedata[31:16] != '0) begin
                  s_d.factor = (avs_req.writedata[31:16] != '0) ? ACC_FACTOR_MAX : ACC_FACTOR_MIN;
               end else if (avs_req.writedata[15:0] > ACC_FACTOR_MAX) begin
                  s_d.factor = ACC_FACTOR_MAX;
               end else begin
                  s_d.factor = avs_req.writedata[15:0];
               end
            end
            REG_EXT_CMD: s_d.ext_cmd = avs_req.writedata;
            default: begin
            end
         endcase
      end
      // Cyclic channel overrides bus in same cycle
      if (vel_ctrl_in_wr) begin
         s_d.vctrl = vel_ctrl_in;
      end
      // Control cycle divider
      // Free running, so tick spacing never depends on bus traffic
      s_d.tick = 1'b0;
      if (s_q.div >= 32'(CYCLE_CLKS - 1)) begin
         s_d.div = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 32'h1;
      end
      // Per control cycle work
      if (s_q.tick) begin
         // Motor potentiometer steps by one unit
         // Both directions at once hold the value
         if (s_q.vctrl[VC_MPOT_UP] && !s_q.vctrl[VC_MPOT_DN]) begin
            s_d.mpot = sat32($signed({s_q.mpot[31], s_q.mpot}) + 33'sh1);
         end else if (s_q.vctrl[VC_MPOT_DN] && !s_q.vctrl[VC_MPOT_UP]) begin
            s_d.mpot = sat32($signed({s_q.mpot[31], s_q.mpot}) - 33'sh1);
         end
         // Ramp step, frozen by run-up stop
         if (!s_q.vctrl[VC_RUNUP_STOP]) begin
            if (diff > 0) begin
               // Rising toward the command
               s_d.rout = (diff > $signed({1'b0, slope})) ? sat32($signed({s_q.rout[31], s_q.rout})
                  + $signed({1'b0, slope})) : cmd;
            end else if (diff < 0) begin
               // Falling toward the command
               s_d.rout = (-diff > $signed({1'b0, slope})) ? sat32($signed({s_q.rout[31], s_q.rout})
                  - $signed({1'b0, slope})) : cmd;
            end
         end
         // Status mirrors the slope choice
         s_d.stage2 = use_acc2;
         // Square wave sequencer
         s_d.cnt = s_q.cnt + 32'h1;
         s_d.pcnt = s_q.pcnt + 32'h1;
         case (s_q.gst)
            // Waiting for enable
            G_IDLE: begin
               if (s_q.gen_en) begin
                  s_d.gst = G_HIGH;
                  s_d.cnt = '0;
                  s_d.pcnt = '0;
               end
            end
            // Positive half phase
            G_HIGH: begin
               if (s_q.cnt + 32'h1 >= s_q.dur1) begin
                  s_d.gst = G_LOW;
                  s_d.cnt = '0;
               end
            end
            // Negative half phase
            G_LOW: begin
               if (s_q.cnt + 32'h1 >= s_q.dur2) begin
                  s_d.gst = G_REST;
                  s_d.cnt = '0;
               end
            end
            // Offset only until period end
            G_REST: begin
            end
            default: s_d.gst = G_IDLE;
         endcase
         // Period end restarts the cycle
         // A period no longer than both phases together cuts the rest phase out
         if (s_q.gst != G_IDLE && s_q.pcnt + 32'h1 >= s_q.period && s_d.gst == G_REST) begin
            s_d.gst = G_HIGH;
            s_d.cnt = '0;
            s_d.pcnt = '0;
         end
         // Disable returns to idle; the last value stays on the output
         if (!s_q.gen_en) begin
            s_d.gst = G_IDLE;
         end
         // Output value for the phase just entered
         case (s_d.gst)
            G_HIGH: s_d.gout.value = sat32($signed({s_q.offset[31], s_q.offset}) + half);
            G_LOW: s_d.gout.value = sat32($signed({s_q.offset[31], s_q.offset}) - half);
            G_REST: s_d.gout.value = s_q.offset;
            default: s_d.gout.value = s_q.gout.value;
         endcase
         // Result write, on every tick outside idle, carries the target identifier
         s_d.gout.write = (s_d.gst != G_IDLE);
         s_d.gout.target = s_q.target;
      end
   end

   // State register, volatile reset values
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.ampl <= GEN_AMPL_RST;
         s_q.vctrl <= VEL_CTRL_RST;
         s_q.factor <= ACC_FACTOR_RST;
         s_q.gst <= G_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign avs_waitrequest = (avs_req.read | avs_req.write) & ~s_q.ack;
   assign avs_readdata = s_q.rdata;
   assign gen_out = s_q.gout;
   assign ramp_out = s_q.rout;
   assign ctrl_tick = s_q.tick;
endmodule

// ### tb/vrt_core_properties.sv
// Port checks of the velocity ramp block, bound to its top module
`timescale 1ns/1ps
module vrt_core_properties import vrt_pkg::*; #(
   parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire vrt_avl_req_t avs_req,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic [9:0] vel_ctrl_in,
   input wire logic vel_ctrl_in_wr,
   input wire vrt_gen_out_t gen_out,
   input wire logic [31:0] ramp_out,
   input wire logic ctrl_tick
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic req; // Any bus request
   logic [31:0] gap_q; // Cycles since last tick
   logic seen_q; // First tick seen
   assign req = avs_req.read | avs_req.write;
   // Counts the spacing of control ticks
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         gap_q <= 32'h0;
         seen_q <= 1'b0;
      end else if (ctrl_tick) begin
         gap_q <= 32'h0;
         seen_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 32'h1;
      end
   end
   property p_wait_start; $rose(req) |-> avs_waitrequest; endproperty
   a_wait_start: assert property (p_wait_start) else $error("no wait state on new request");
   property p_wait_one; req && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest longer than one cycle");
   property p_wait_idle; !req |-> !avs_waitrequest; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
   property p_tick_gap; seen_q |-> (ctrl_tick == (gap_q == CYCLE_CLKS - 1)); endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("control tick spacing wrong");
   property p_gen_write; gen_out.write |-> $past(ctrl_tick); endproperty
   a_gen_write: assert property (p_gen_write) else $error("result write off the tick");
   property p_gen_once; gen_out.write |=> !gen_out.write; endproperty
   a_gen_once: assert property (p_gen_once) else $error("result write longer than a pulse");
   property p_gen_hold; !$past(ctrl_tick) |-> $stable(gen_out.value); endproperty
   a_gen_hold: assert property (p_gen_hold) else $error("result moved between ticks");
   property p_ramp_hold; !$past(ctrl_tick) |-> $stable(ramp_out); endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved between ticks");
   property p_rdata_hold; $changed(avs_readdata) |-> $past(avs_req.read); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
endmodule
bind vrt_core vrt_core_properties #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (.ref_clk(ref_clk), .resetn(resetn),
   .avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
   .vel_ctrl_in(vel_ctrl_in), .vel_ctrl_in_wr(vel_ctrl_in_wr), .gen_out(gen_out),
   .ramp_out(ramp_out), .ctrl_tick(ctrl_tick));

// ### tb/vrt_host_model.sv
// Cyclic control word source standing in for the drive master
`timescale 1ns/1ps
module vrt_host_model (
   input wire logic ref_clk,
   output logic [9:0] vel_ctrl_in,
   output logic vel_ctrl_in_wr
);
   // Idle value is a pattern, never a stale word
   initial begin
      vel_ctrl_in = 10'h2AA;
      vel_ctrl_in_wr = 1'b0;
   end
   // One strobe per word, then the value is scrambled
   task automatic send(input logic [9:0] w);
      @(posedge ref_clk);
      vel_ctrl_in <= w;
      vel_ctrl_in_wr <= 1'b1;
      @(posedge ref_clk);
      vel_ctrl_in_wr <= 1'b0;
      vel_ctrl_in <= ~w;
   endtask
endmodule

// ### tb/tb.sv
// Self-checking bench of the velocity ramp and test signal block
`timescale 1ns/1ps
module tb import vrt_pkg::*; ();
   localparam int CYC = 16; // Short control cycle
   localparam int LIMIT = 20000; // Hang ceiling in cycles
   logic ref_clk;
   logic resetn;
   vrt_avl_req_t req;
   logic wait_req;
   logic [31:0] rdata;
   logic [9:0] vc_in;
   logic vc_wr;
   vrt_gen_out_t gen;
   logic [31:0] ramp;
   logic tick;
   int miscompares;
   int compares;
   int cycles;
   // Reference clock, 100 ns
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   vrt_core #(.CYCLE_CLKS(CYC), .TAB_DEPTH(16)) DUT (.ref_clk(ref_clk), .resetn(resetn), .avs_req(req),
      .avs_waitrequest(wait_req), .avs_readdata(rdata), .vel_ctrl_in(vc_in), .vel_ctrl_in_wr(vc_wr),
      .gen_out(gen), .ramp_out(ramp), .ctrl_tick(tick));
   vrt_host_model u_host (.ref_clk(ref_clk), .vel_ctrl_in(vc_in), .vel_ctrl_in_wr(vc_wr));
   // Closing report
   task print_verdict;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycle; waitrequest and read data taken at the same rising edge
   task bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      req.read <= rd;
      req.write <= !rd;
      req.address <= a;
      req.writedata <= d;
      do begin
         @(posedge ref_clk);
      end while (wait_req !== 1'b0);
      q = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b1, a, 32'h0, q);
      chk(q, e);
   endtask
   // Waits for the edge where tick outputs update
   task wait_tick;
      do begin
         @(negedge ref_clk);
      end while (tick !== 1'b1);
      @(posedge ref_clk);
      #1;
   endtask
   task step(input logic [31:0] e);
      wait_tick;
      chk(ramp, e);
   endtask
   task t_regs;
      rd_chk(REG_GEN_AMPL, GEN_AMPL_RST);
      rd_chk(REG_VEL_CTRL, 32'h0);
      rd_chk(REG_ACC_FACTOR, {16'h0, ACC_FACTOR_RST});
      wr(REG_VEL_CTRL, 32'hFFFFFFFF);
      rd_chk(REG_VEL_CTRL, {22'h0, VEL_CTRL_MAX});
      rd_chk(8'h50, 32'h0);
      wr(REG_VEL_CTRL, 32'h0);
   endtask
   // Square wave: +10 for 2, -10 for 1, rest to period 5, offset -5
   task t_gen;
      logic [31:0] e [6] = '{32'h5, 32'h5, 32'hFFFFFFF1, 32'hFFFFFFFB, 32'hFFFFFFFB, 32'h5};
      wr(REG_GEN_TARGET, 32'h1234);
      wr(REG_GEN_OFFSET, 32'hFFFFFFFB);
      wr(REG_GEN_AMPL, 32'h14);
      wr(REG_GEN_DUR1, 32'h2);
      wr(REG_GEN_DUR2, 32'h1);
      wr(REG_GEN_PERIOD, 32'h5);
      wr(REG_GEN_CTRL, 32'h1);
      for (int i = 0; i < 6; i++) begin
         do begin
            @(negedge ref_clk);
         end while (gen.write !== 1'b1);
         chk(gen.value, e[i]);
         chk({16'h0, gen.target}, 32'h1234);
      end
      wr(REG_GEN_CTRL, 32'h0);
      wait_tick;
      chk({31'h0, gen.write}, 32'h0);
      rd_chk(REG_GEN_OUT, 32'h5);
      rd_chk(REG_STATUS, 32'h4);
   endtask
   // Slope 10 up to 25, then 3, clamped at 40
   task t_ramp_up;
      wr(REG_ACC1, 32'hA);
      wr(REG_FINAL_SPEED, 32'h19);
      wr(REG_ACC2, 32'h3);
      wr(REG_DEC1, 32'h4);
      wr(REG_DEC2, 32'h7);
      wait_tick;
      wr(REG_EXT_CMD, 32'h28);
      step(32'hA);
      step(32'h14);
      step(32'h1E);
      step(32'h21);
      rd_chk(REG_STATUS, 32'hC);
      step(32'h24);
      step(32'h27);
      step(32'h28);
   endtask
   // Down at 4 above 25, then 7 below it, clamped at 0
   task t_ramp_down;
      logic [31:0] e [8] = '{32'h24, 32'h20, 32'h1C, 32'h18, 32'h11, 32'hA, 32'h3, 32'h0};
      wait_tick;
      wr(REG_EXT_CMD, 32'h0);
      for (int i = 0; i < 8; i++) begin
         step(e[i]);
      end
   endtask
   // Second stage off, then masking doubles slope one
   task t_stage_mask;
      wr(REG_ACC2, 32'h0);
      wait_tick;
      wr(REG_EXT_CMD, 32'h28);
      step(32'hA);
      step(32'h14);
      step(32'h1E);
      step(32'h28);
      wr(REG_ACC_FACTOR, 32'hC8);
      wr(REG_VEL_CTRL, 32'h40);
      wait_tick;
      wr(REG_EXT_CMD, 32'h50);
      step(32'h3C);
      step(32'h50);
   endtask
   // Table entries picked by cyclic control word index
   task t_table;
      wr(REG_ACC1, 32'h3E8);
      wr(REG_DEC1, 32'h3E8);
      wr(REG_DEC2, 32'h3E8);
      wr(8'h8C, 32'hFA);
      wr(8'hBC, 32'hFFFFFFBA);
      rd_chk(8'h8C, 32'h0);
      wait_tick;
      u_host.send(10'h013);
      step(32'hFA);
      wait_tick;
      u_host.send(10'h01F);
      step(32'hFFFFFFBA);
      rd_chk(REG_VEL_CTRL, 32'h1F);
   endtask
   // Run-up stop freezes the ramp, then the potentiometer leads it
   task t_pot;
      wait_tick;
      u_host.send(10'h0A0);
      step(32'hFFFFFFBA);
      u_host.send(10'h180);
      step(32'h0);
      step(32'h1);
      rd_chk(REG_RAMP_OUT, 32'h1);
   endtask
   // Main sequence
   initial begin
      req = '0;
      resetn = 1'b0;
      miscompares = 0;
      compares = 0;
      cycles = 0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs;
      t_gen;
      t_ramp_up;
      t_ramp_down;
      t_stage_mask;
      t_table;
      t_pot;
      print_verdict;
   end
endmodule
